// [tw_pkg.sv]
package tw_pkg;

  // Fixed upper part of the seven-bit device address and the default of the configurable lower part.
  localparam logic [2:0] ADDR_HI       = 3'h3;
  localparam logic [3:0] ADDR_LOW_DEF  = 4'h6;

  // Memory map limits seen by the serial port.
  localparam logic [7:0] LAST_AUTO_WR  = 8'h4f;
  localparam logic [7:0] FUNC_REQ_ADDR = 8'hfe;
  localparam logic [7:0] PAST_END_BYTE = 8'hff;

  // Bits per byte and the index of the last data bit.
  localparam logic [3:0] BYTE_BITS     = 4'h8;
  localparam logic [3:0] LAST_BIT      = 4'h7;

  // Direction bit values.
  localparam logic       DIR_WRITE     = 1'b0;
  localparam logic       DIR_READ      = 1'b1;

  // Serial clock made by the master end: period in ns, split into four phases of whole clk cycles.
  localparam int         CLK_PERIOD_NS = 8;
  localparam int         SCL_PERIOD_NS = 2500;
  localparam int         QTR_CYC       = (SCL_PERIOD_NS / 4 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [6:0] QTR_LAST      = 7'(QTR_CYC - 1);

  // Width of a buffered write word on the device end: address and data.
  localparam int         WR_WORD_W     = 16;

endpackage

// [tw_bus_if.sv]
`timescale 1ns/100ps
`default_nettype none

// Open-drain two-wire bus with a pull-up: a line is low while any enabled driver pulls it low.
interface tw_bus_if;
  logic m_scl_o;
  logic m_scl_oe;
  logic m_sda_o;
  logic m_sda_oe;
  logic s_sda_o;
  logic s_sda_oe;
  logic scl;
  logic sda;

  assign scl = !(m_scl_oe && !m_scl_o);
  assign sda = !(m_sda_oe && !m_sda_o) && !(s_sda_oe && !s_sda_o);

  modport master (output m_scl_o, output m_scl_oe, output m_sda_o, output m_sda_oe, input scl, input sda);
  modport slave  (output s_sda_o, output s_sda_oe, input scl, input sda);
endinterface

`default_nettype wire

// [tw_fifo2.sv]
`timescale 1ns/100ps
`default_nettype none

// Two-entry buffer; ready and valid come from flops.
module tw_fifo2 #(
  parameter int W = 8
) (
  input  wire logic         clk,
  input  wire logic         srst,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);
  logic [W-1:0] mem_r [0:1];
  logic         wr_ptr_r;
  logic         rd_ptr_r;
  logic [1:0]   cnt_r;
  logic [1:0]   cnt_nxt;
  logic         push;
  logic         pop;

  assign push     = in_valid && in_ready;
  assign pop      = out_valid && out_ready;
  assign cnt_nxt  = cnt_r + {1'b0, push} - {1'b0, pop};
  assign out_data = mem_r[rd_ptr_r];

  always_ff @(posedge clk) begin
    if (push) begin
      mem_r[wr_ptr_r] <= in_data;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      wr_ptr_r  <= 1'b0;
      rd_ptr_r  <= 1'b0;
      cnt_r     <= 2'h0;
      in_ready  <= 1'b0;
      out_valid <= 1'b0;
    end else begin
      wr_ptr_r  <= wr_ptr_r ^ push;
      rd_ptr_r  <= rd_ptr_r ^ pop;
      cnt_r     <= cnt_nxt;
      in_ready  <= cnt_nxt != 2'h2;
      out_valid <= cnt_nxt != 2'h0;
    end
  end
endmodule

`default_nettype wire

// [tw_slave.sv]
// How it works
// RULE1 - Master writes: address, memory address, data, stop.
// RULE2 - Bare matching address gets an acknowledge.
// RULE3 - Receiver acknowledges every byte before the next.
// RULE4 - First byte at given address; pointer then increments.
// RULE5 - Auto-increment beyond 4Fh discards further writes.
// RULE6 - Read-only or reserved locations ignore writes.
// RULE7 - Auto-increment reaching function request byte discards.
// RULE8 - Incomplete or refused bytes are never stored.
// RULE9 - Writes reach shadow copies only, never nonvolatile.
// RULE10 - Master ends writes with stop or restart.
// RULE11 - Read: write address, restart, address with read.
// RULE12 - Device drives data from address acknowledge onward.
// RULE13 - During writes device drives only acknowledge cycles.
// RULE14 - Read sends MSB first, increments, next byte follows.
// RULE15 - Reads past FFh return FFh.
// RULE16 - Master ends read with no-acknowledge, then stop.
// RULE17 - After no-acknowledge the device releases data line.
// RULE18 - Address is 011 plus configurable four bits.
// RULE19 - Direction zero writes, direction one reads.
// RULE20 - Eight bits MSB first, then acknowledge bit.
// RULE21 - Acknowledge holds data low through ninth clock.
// RULE22 - Foreign address: no acknowledge, ignore until start.
`timescale 1ns/100ps
`default_nettype none

module tw_slave (
  input  wire logic                     clk,
  input  wire logic                     srst,
  tw_bus_if.slave                       bus,
  input  wire logic [3:0]               addr_low,
  output logic [7:0]                    mem_ptr,
  input  wire logic [7:0]               rd_data,
  input  wire logic                     loc_writable,
  output logic                          wr_valid,
  input  wire logic                     wr_ready,
  output logic [tw_pkg::WR_WORD_W-1:0]  wr_word
);
  import tw_pkg::*;

  typedef enum logic [2:0] {SS_IDLE, SS_RX, SS_ACK, SS_TX, SS_MACK, SS_SKIP} tw_sst_t;
  typedef enum logic [1:0] {BK_ADDR, BK_MADDR, BK_DATA} tw_kind_t;

  tw_sst_t    st_r;
  tw_kind_t   kind_r;
  logic [3:0] cnt_r;
  logic [7:0] sh_r;
  logic [7:0] tx_r;
  logic [8:0] ptr_r;
  logic       first_r;
  logic       rw_r;
  logic       ok_r;
  logic       ack_r;
  logic       nak_r;
  logic [7:0] pend_addr_r;
  logic [7:0] pend_data_r;
  logic       sda_oe_r;
  logic       sda_o_r;

  logic       scl_s1;
  logic       scl_s2;
  logic       scl_d;
  logic       sda_s1;
  logic       sda_s2;
  logic       sda_d;

  logic       scl_rise;
  logic       scl_fall;
  logic       bus_start;
  logic       bus_stop;
  logic       addr_match;
  logic       wr_ok;
  logic [7:0] tx_byte;
  logic [8:0] ptr_inc;
  logic       wq_in_ready;
  logic       wq_push;

  // Both bus lines cross into clk through two flops; the third flop only feeds edge detection.
  always_ff @(posedge clk) begin
    if (srst) begin
      scl_s1 <= 1'b1;
      scl_s2 <= 1'b1;
      scl_d  <= 1'b1;
      sda_s1 <= 1'b1;
      sda_s2 <= 1'b1;
      sda_d  <= 1'b1;
    end else begin
      scl_s1 <= bus.scl;
      scl_s2 <= scl_s1;
      scl_d  <= scl_s2;
      sda_s1 <= bus.sda;
      sda_s2 <= sda_s1;
      sda_d  <= sda_s2;
    end
  end

  assign scl_rise   = scl_s2 && !scl_d;
  assign scl_fall   = !scl_s2 && scl_d;
  assign bus_start  = scl_s2 && scl_d && sda_d && !sda_s2;
  assign bus_stop   = scl_s2 && scl_d && !sda_d && sda_s2;
  assign addr_match = sh_r[7:1] == {ADDR_HI, addr_low}; // RULE18

  // A byte may be stored only when addressed directly or reached by auto-increment inside the writable range.
  assign wr_ok      = loc_writable && !ptr_r[8] // RULE6
                      && (first_r || ptr_r[7:0] <= LAST_AUTO_WR) // RULE5
                      && !(!first_r && ptr_r[7:0] == FUNC_REQ_ADDR); // RULE7
  assign tx_byte    = ptr_r[8] ? PAST_END_BYTE : rd_data; // RULE15
  assign ptr_inc    = ptr_r[8] ? ptr_r : ptr_r + 9'h001;
  assign wq_push    = st_r == SS_ACK && scl_fall && kind_r == BK_DATA && ok_r && ack_r; // RULE8 RULE9
  assign mem_ptr    = ptr_r[7:0];
  assign bus.s_sda_oe = sda_oe_r;
  assign bus.s_sda_o  = sda_o_r;

  // Accepted bytes wait here for the storage side; when both entries are taken the byte is refused.
  tw_fifo2 #(
    .W (WR_WORD_W)
  ) u_wq (
    .clk       (clk),
    .srst      (srst),
    .in_valid  (wq_push),
    .in_ready  (wq_in_ready),
    .in_data   ({pend_addr_r, pend_data_r}),
    .out_valid (wr_valid),
    .out_ready (wr_ready),
    .out_data  (wr_word)
  );

  always_ff @(posedge clk) begin
    if (srst) begin
      st_r        <= SS_IDLE;
      kind_r      <= BK_ADDR;
      cnt_r       <= 4'h0;
      sh_r        <= 8'h00;
      tx_r        <= 8'h00;
      ptr_r       <= 9'h000;
      first_r     <= 1'b0;
      rw_r        <= DIR_WRITE;
      ok_r        <= 1'b0;
      ack_r       <= 1'b0;
      nak_r       <= 1'b0;
      pend_addr_r <= 8'h00;
      pend_data_r <= 8'h00;
      sda_oe_r    <= 1'b0;
      sda_o_r     <= 1'b0;
    end else if (bus_start) begin
      st_r     <= SS_RX;
      kind_r   <= BK_ADDR;
      cnt_r    <= 4'h0;
      sda_oe_r <= 1'b0;
    end else if (bus_stop) begin
      st_r     <= SS_IDLE;
      sda_oe_r <= 1'b0;
    end else begin
      unique case (st_r)
        SS_IDLE, SS_SKIP: begin
          sda_oe_r <= 1'b0; // RULE22
        end
        SS_RX: begin
          if (scl_rise) begin
            sh_r  <= {sh_r[6:0], sda_s2}; // RULE20
            cnt_r <= cnt_r + 4'h1;
          end else if (scl_fall && cnt_r == BYTE_BITS) begin
            unique case (kind_r)
              BK_ADDR: begin
                if (addr_match) begin
                  rw_r     <= sh_r[0]; // RULE19
                  sda_oe_r <= 1'b1; // RULE2 RULE21
                  st_r     <= SS_ACK;
                end else begin
                  st_r <= SS_SKIP; // RULE22
                end
              end
              BK_MADDR: begin
                ptr_r    <= {1'b0, sh_r}; // RULE4
                first_r  <= 1'b1;
                sda_oe_r <= 1'b1; // RULE3
                st_r     <= SS_ACK;
              end
              default: begin
                ok_r        <= wr_ok;
                ack_r       <= wq_in_ready;
                sda_oe_r    <= wq_in_ready; // RULE3 RULE8
                pend_addr_r <= ptr_r[7:0];
                pend_data_r <= sh_r;
                ptr_r       <= ptr_inc; // RULE4
                first_r     <= 1'b0;
                st_r        <= SS_ACK;
              end
            endcase
          end
        end
        SS_ACK: begin
          if (scl_fall) begin
            cnt_r <= 4'h0;
            if (kind_r == BK_ADDR && rw_r == DIR_READ) begin
              tx_r     <= tx_byte; // RULE14
              sda_oe_r <= !tx_byte[7]; // RULE12
              st_r     <= SS_TX;
            end else begin
              sda_oe_r <= 1'b0; // RULE13
              st_r     <= SS_RX;
              if (kind_r == BK_ADDR) begin
                kind_r <= BK_MADDR;
              end else begin
                kind_r <= BK_DATA;
              end
            end
          end
        end
        SS_TX: begin
          if (scl_fall) begin
            if (cnt_r == LAST_BIT) begin
              sda_oe_r <= 1'b0;
              ptr_r    <= ptr_inc; // RULE14
              st_r     <= SS_MACK;
            end else begin
              cnt_r    <= cnt_r + 4'h1;
              tx_r     <= {tx_r[6:0], 1'b0};
              sda_oe_r <= !tx_r[6]; // RULE12
            end
          end
        end
        SS_MACK: begin
          if (scl_rise) begin
            nak_r <= sda_s2;
          end else if (scl_fall) begin
            cnt_r <= 4'h0;
            if (nak_r) begin
              sda_oe_r <= 1'b0; // RULE17
              st_r     <= SS_SKIP;
            end else begin
              tx_r     <= tx_byte; // RULE14 RULE15
              sda_oe_r <= !tx_byte[7];
              st_r     <= SS_TX;
            end
          end
        end
        default: begin
          st_r     <= SS_IDLE;
          sda_oe_r <= 1'b0;
        end
      endcase
    end
  end
endmodule

`default_nettype wire

// [tw_master.sv]
`timescale 1ns/100ps
`default_nettype none

module tw_master (
  input  wire logic       clk,
  input  wire logic       srst,
  tw_bus_if.master        bus,
  input  wire logic       cmd_valid,
  output logic            cmd_ready,
  input  wire logic       cmd_read,
  input  wire logic [6:0] cmd_dev,
  input  wire logic [7:0] cmd_maddr,
  input  wire logic [7:0] cmd_len,
  input  wire logic       wd_valid,
  output logic            wd_ready,
  input  wire logic [7:0] wd_data,
  output logic            rd_valid,
  input  wire logic       rd_ready,
  output logic [7:0]      rd_data,
  output logic            done,
  output logic            nak
);
  import tw_pkg::*;

  typedef enum logic [1:0] {MS_IDLE, MS_START, MS_BYTE, MS_STOP} tw_mst_t;
  typedef enum logic [2:0] {K_SADDR_W, K_MADDR, K_WDATA, K_SADDR_R, K_RDATA} tw_mkind_t;

  tw_mst_t    st_r;
  tw_mkind_t  kind_r;
  logic [6:0] qcnt_r;
  logic [1:0] ph_r;
  logic [3:0] bit_r;
  logic [7:0] sh_r;
  logic [7:0] len_r;
  logic [7:0] maddr_r;
  logic [6:0] dev_r;
  logic       rd_r;
  logic       nak_seen_r;
  logic       sda_s1;
  logic       sda_s2;
  logic       scl_oe_r;
  logic       sda_oe_r;

  logic       tick;
  logic       rx;
  logic       stall;
  logic       step;
  logic       drv_scl;
  logic       drv_sda;
  logic       tx_msb;
  logic       wq_valid;
  logic       wq_pop;
  logic [7:0] wq_data;
  logic       rq_ready;
  logic       rq_push;

  assign tick     = qcnt_r == QTR_LAST;
  assign rx       = kind_r == K_RDATA;
  // Before the first bit of a data byte the clock is held low until a byte to send, or room for one read, exists.
  assign stall    = st_r == MS_BYTE && bit_r == 4'h0 && ph_r == 2'h0
                    && ((kind_r == K_WDATA && !wq_valid) || (rx && !rq_ready));
  assign step     = tick && !stall && st_r != MS_IDLE;
  assign wq_pop   = step && st_r == MS_BYTE && ph_r == 2'h0 && bit_r == 4'h0 && kind_r == K_WDATA;
  assign rq_push  = step && st_r == MS_BYTE && ph_r == 2'h3 && bit_r == BYTE_BITS && rx;
  assign drv_scl  = (st_r == MS_START || st_r == MS_BYTE) ? (ph_r == 2'h0 || ph_r == 2'h3)
                  : (st_r == MS_STOP && ph_r == 2'h0);
  // The first bit of a write byte comes from the buffer head, as the shifter loads it only when the clock rises.
  assign tx_msb   = (kind_r == K_WDATA && bit_r == 4'h0 && ph_r == 2'h0) ? (wq_valid && wq_data[7]) : sh_r[7];
  // Acknowledge every read byte except the last wanted one.
  assign drv_sda  = st_r == MS_START ? ph_r[1]
                  : st_r == MS_STOP ? !ph_r[1]
                  : st_r != MS_BYTE ? 1'b0
                  : bit_r == BYTE_BITS ? (rx && len_r != 8'h01) // RULE3 RULE16 RULE21
                  : (!rx && !tx_msb); // RULE20

  assign bus.m_scl_oe = scl_oe_r;
  assign bus.m_sda_oe = sda_oe_r;
  assign bus.m_scl_o  = 1'b0;
  assign bus.m_sda_o  = 1'b0;

  tw_fifo2 #(.W(8)) u_wq (
    .clk (clk), .srst (srst), .in_valid (wd_valid), .in_ready (wd_ready), .in_data (wd_data),
    .out_valid (wq_valid), .out_ready (wq_pop), .out_data (wq_data)
  );

  tw_fifo2 #(.W(8)) u_rq (
    .clk (clk), .srst (srst), .in_valid (rq_push), .in_ready (rq_ready), .in_data (sh_r),
    .out_valid (rd_valid), .out_ready (rd_ready), .out_data (rd_data)
  );

  always_ff @(posedge clk) begin
    if (srst) begin
      qcnt_r   <= 7'h00;
      sda_s1   <= 1'b1;
      sda_s2   <= 1'b1;
      scl_oe_r <= 1'b0;
      sda_oe_r <= 1'b0;
    end else begin
      qcnt_r   <= tick ? 7'h00 : qcnt_r + 7'h01;
      sda_s1   <= bus.sda;
      sda_s2   <= sda_s1;
      scl_oe_r <= drv_scl;
      sda_oe_r <= drv_sda;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      st_r       <= MS_IDLE;
      kind_r     <= K_SADDR_W;
      ph_r       <= 2'h0;
      bit_r      <= 4'h0;
      sh_r       <= 8'h00;
      len_r      <= 8'h00;
      maddr_r    <= 8'h00;
      dev_r      <= 7'h00;
      rd_r       <= 1'b0;
      nak_seen_r <= 1'b0;
      cmd_ready  <= 1'b0;
      done       <= 1'b0;
      nak        <= 1'b0;
    end else begin
      done <= 1'b0;
      if (st_r == MS_IDLE) begin
        cmd_ready <= 1'b1;
        ph_r      <= 2'h0;
        if (cmd_valid && cmd_ready) begin
          cmd_ready <= 1'b0;
          nak       <= 1'b0;
          rd_r      <= cmd_read;
          dev_r     <= cmd_dev;
          maddr_r   <= cmd_maddr;
          len_r     <= cmd_len;
          kind_r    <= K_SADDR_W; // RULE1 RULE11
          st_r      <= MS_START;
        end
      end else if (step) begin
        ph_r <= ph_r + 2'h1;
        unique case (st_r)
          MS_START: begin
            if (ph_r == 2'h3) begin
              st_r  <= MS_BYTE;
              bit_r <= 4'h0;
              sh_r  <= {dev_r, kind_r == K_SADDR_R}; // RULE19
            end
          end
          MS_STOP: begin
            if (ph_r == 2'h3) begin
              st_r <= MS_IDLE;
              done <= 1'b1;
            end
          end
          default: begin
            if (ph_r == 2'h0 && bit_r == 4'h0 && kind_r == K_WDATA) begin
              sh_r <= wq_data;
            end
            if (ph_r == 2'h2) begin
              if (bit_r != BYTE_BITS && rx) begin
                sh_r <= {sh_r[6:0], sda_s2};
              end
              if (bit_r == BYTE_BITS) begin
                nak_seen_r <= sda_s2 && !rx; // RULE3
              end
            end
            if (ph_r == 2'h3 && bit_r != BYTE_BITS) begin
              bit_r <= bit_r + 4'h1;
              if (!rx) begin
                sh_r <= {sh_r[6:0], 1'b0};
              end
            end
            if (ph_r == 2'h3 && bit_r == BYTE_BITS) begin
              bit_r <= 4'h0;
              if (nak_seen_r) begin
                nak  <= 1'b1;
                st_r <= MS_STOP;
              end else begin
                unique case (kind_r)
                  K_SADDR_W: begin
                    kind_r <= K_MADDR;
                    sh_r   <= maddr_r;
                  end
                  K_MADDR: begin
                    if (len_r == 8'h00) begin
                      st_r <= MS_STOP; // RULE10
                    end else if (rd_r) begin
                      kind_r <= K_SADDR_R; // RULE11
                      st_r   <= MS_START;
                    end else begin
                      kind_r <= K_WDATA;
                    end
                  end
                  K_SADDR_R: begin
                    kind_r <= K_RDATA;
                  end
                  default: begin
                    len_r <= len_r - 8'h01;
                    if (len_r == 8'h01) begin
                      st_r <= MS_STOP; // RULE10 RULE16
                    end
                  end
                endcase
              end
            end
          end
        endcase
      end
    end
  end
endmodule

`default_nettype wire

// [tw_link_asserts.sv]
`timescale 1ns/100ps
`default_nettype none

module tw_link_asserts (
  input wire logic clk,
  input wire logic srst,
  input wire logic m_sda_oe,
  input wire logic s_sda_oe,
  input wire logic scl,
  input wire logic sda,
  input wire logic [3:0] addr_low
);
  import tw_pkg::*;

  logic       scl_r;
  logic       sda_r;
  logic       first_r;
  logic       rdm_r;
  logic [3:0] bitc_r;
  logic [7:0] sh_r;
  wire        rise  = scl && !scl_r;
  wire        fall  = !scl && scl_r;
  wire        start = scl && scl_r && sda_r && !sda;
  wire        stop  = scl && scl_r && !sda_r && sda;
  wire        match = sh_r[7:1] == {ADDR_HI, addr_low};

  always_ff @(posedge clk) begin
    scl_r <= scl;
    sda_r <= sda;
  end

  // Tracks bit index, first byte after a start and read direction.
  always_ff @(posedge clk) begin
    if (srst || start || stop) begin
      // A start parks the count one below zero, so the clock fall that ends the start leaves bit zero.
      bitc_r  <= (start && !srst) ? 4'hf : 4'h0;
      first_r <= start && !srst;
      rdm_r   <= 1'b0;
    end else if (fall) begin
      bitc_r  <= (bitc_r == 4'h8) ? 4'h0 : bitc_r + 4'h1;
      first_r <= first_r && bitc_r != 4'h8;
      rdm_r   <= rdm_r || (first_r && bitc_r == 4'h8 && sh_r[1] && !sh_r[0]);
    end else if (rise) begin
      sh_r <= {sh_r[6:0], sda};
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  a_addr_ack: assert property (rise && first_r && bitc_r == 4'h8 |-> s_sda_oe == match)
    else $error("address acknowledge wrong");
  a_ack_within: assert property (fall && first_r && bitc_r == 4'h7 && match |-> ##[1:8] s_sda_oe)
    else $error("address acknowledge late");
  a_write_quiet: assert property (scl && !rdm_r && s_sda_oe |-> bitc_r == 4'h8)
    else $error("slave drives outside acknowledge");
  a_read_ack_free: assert property (scl && rdm_r && bitc_r == 4'h8 |-> !s_sda_oe)
    else $error("slave drives master acknowledge");
  a_nak_release: assert property (rise && rdm_r && bitc_r == 4'h8 && sda |-> ##200 !s_sda_oe)
    else $error("slave drives after no acknowledge");
  a_no_overlap: assert property (scl |-> !(s_sda_oe && m_sda_oe))
    else $error("both ends drive data while clock high");
  a_high_stable: assert property (scl && $past(scl) |-> $stable(s_sda_oe))
    else $error("slave data changes while clock high");
  a_slave_lag: assert property ($changed(s_sda_oe) |-> !scl && !$past(scl) && !$past(scl, 2))
    else $error("slave changes data too soon after clock fall");
endmodule

`default_nettype wire

// [tb_top.sv]
`timescale 1ns/100ps
`default_nettype none

module tb_top;
  import tw_pkg::*;

  typedef struct packed {
    logic        rd;
    logic [6:0]  dev;
    logic [7:0]  maddr;
    logic [7:0]  len;
    logic [23:0] dat;
    logic [2:0]  keep;
    logic        nak;
  } tw_row_t;

  localparam tw_row_t ROWS [6] = '{
    '{1'b0, 7'h36, 8'h4e, 8'h03, 24'ha1b2c3, 3'h3, 1'b0},
    '{1'b0, 7'h36, 8'h1f, 8'h02, 24'h112200, 3'h1, 1'b0},
    '{1'b0, 7'h36, 8'hfd, 8'h02, 24'h334400, 3'h1, 1'b0},
    '{1'b1, 7'h36, 8'hfe, 8'h03, 24'h0100ff, 3'h0, 1'b0},
    '{1'b0, 7'h37, 8'h00, 8'h00, 24'h000000, 3'h0, 1'b1},
    '{1'b0, 7'h36, 8'h00, 8'h00, 24'h000000, 3'h0, 1'b0}
  };

  logic        clk       = 1'b0;
  logic        srst      = 1'b1;
  logic        cmd_valid = 1'b0;
  logic        cmd_read  = 1'b0;
  logic [6:0]  cmd_dev   = 7'h00;
  logic [7:0]  cmd_maddr = 8'h00;
  logic [7:0]  cmd_len   = 8'h00;
  logic        wd_valid  = 1'b0;
  logic [7:0]  wd_data   = 8'h00;
  logic        rd_ready  = 1'b1;
  logic        wr_ready  = 1'b1;
  logic [3:0]  addr_low  = ADDR_LOW_DEF;
  logic        cmd_ready;
  logic        wd_ready;
  logic        rd_valid;
  logic [7:0]  m_rd;
  logic        done;
  logic        nak;
  logic [7:0]  mem_ptr;
  logic        wr_valid;
  logic [15:0] wr_word;
  logic [7:0]  mem [256];
  logic [7:0]  st_rd;
  logic        st_ok;
  int          mismatches;
  int          samples_checked;
  int          mon_cnt = 99;
  logic [7:0]  mon_sh;
  logic [7:0]  adr_seen;

  always #(CLK_PERIOD_NS / 2) clk = ~clk;

  tw_bus_if tw_bus_if_i ();

  tw_slave tw_slave_i (.clk(clk), .srst(srst), .bus(tw_bus_if_i.slave), .addr_low(addr_low),
    .mem_ptr(mem_ptr), .rd_data(st_rd), .loc_writable(st_ok), .wr_valid(wr_valid),
    .wr_ready(wr_ready), .wr_word(wr_word));

  tw_master tw_master_i (.clk(clk), .srst(srst), .bus(tw_bus_if_i.master), .cmd_valid(cmd_valid),
    .cmd_ready(cmd_ready), .cmd_read(cmd_read), .cmd_dev(cmd_dev), .cmd_maddr(cmd_maddr),
    .cmd_len(cmd_len), .wd_valid(wd_valid), .wd_ready(wd_ready), .wd_data(wd_data),
    .rd_valid(rd_valid), .rd_ready(rd_ready), .rd_data(m_rd), .done(done), .nak(nak));

  tw_link_asserts tw_link_asserts_i (.clk(clk), .srst(srst), .m_sda_oe(tw_bus_if_i.m_sda_oe),
    .s_sda_oe(tw_bus_if_i.s_sda_oe), .scl(tw_bus_if_i.scl), .sda(tw_bus_if_i.sda), .addr_low(addr_low));

  // Storage model: writable only at 10h-1Fh, 30h-7Fh and FDh-FEh; 50h and up only reachable by a direct address.
  assign st_rd = mem[mem_ptr];
  assign st_ok = mem_ptr inside {[8'h10:8'h1f], [8'h30:8'h7f], [8'hfd:8'hfe]};

  always @(posedge clk) if (wr_valid === 1'b1 && wr_ready) mem[wr_word[15:8]] <= wr_word[7:0];

  // Wire monitor: captures the address byte after the latest start.
  always @(negedge tw_bus_if_i.sda) if (tw_bus_if_i.scl === 1'b1) mon_cnt = 0;
  always @(posedge tw_bus_if_i.scl) begin
    mon_sh = {mon_sh[6:0], tw_bus_if_i.sda};
    if (mon_cnt == 7) adr_seen = mon_sh;
    mon_cnt++;
  end

  task automatic chk_b(input logic got, input logic exp);
    samples_checked++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] %0t bit got %b exp %b", $time, got, exp);
    end
  endtask

  task automatic chk_y(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] %0t byte got %h exp %h", $time, got, exp);
    end
  endtask

  function automatic logic pick(int k);
    case (k)
      0: return cmd_ready;
      1: return wd_ready;
      2: return rd_valid;
      default: return done;
    endcase
  endfunction

  task automatic wait_hi(input int k);
    int n;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pick(k) !== 1'b1 && n < 40000);
    if (n >= 40000) chk_b(1'b0, 1'b1);
  endtask

  task automatic run_row(input tw_row_t r);
    logic [7:0] old [3];
    logic [7:0] got [3];
    for (int i = 0; i < 3; i++) old[i] = mem[8'(r.maddr + i)];
    @(posedge clk);
    cmd_read  <= r.rd;
    cmd_dev   <= r.dev;
    cmd_maddr <= r.maddr;
    cmd_len   <= r.len;
    cmd_valid <= 1'b1;
    fork
      begin
        wait_hi(0);
        cmd_valid <= 1'b0;
      end
      if (!r.rd) begin
        for (int i = 0; i < r.len; i++) begin
          wd_data  <= r.dat[23 - 8 * i -: 8];
          wd_valid <= 1'b1;
          wait_hi(1);
        end
        wd_valid <= 1'b0;
      end
      if (r.rd) begin
        for (int i = 0; i < r.len; i++) begin
          rd_ready <= 1'b0;
          repeat (30) @(posedge clk);
          rd_ready <= 1'b1;
          wait_hi(2);
          got[i] = m_rd;
        end
      end
      wait_hi(3);
    join
    chk_b(nak, r.nak);
    chk_y(adr_seen, {r.dev, r.rd});
    for (int i = 0; i < r.len; i++) begin
      if (r.rd) chk_y(got[i], r.dat[23 - 8 * i -: 8]);
      else chk_y(mem[8'(r.maddr + i)], r.keep[i] ? r.dat[23 - 8 * i -: 8] : old[i]);
    end
  endtask

  task automatic end_sim;
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  initial begin
    for (int i = 0; i < 256; i++) mem[i] = ~8'(i);
    repeat (20) @(posedge clk);
    chk_b(tw_bus_if_i.m_scl_oe | tw_bus_if_i.m_sda_oe | tw_bus_if_i.s_sda_oe, 1'b0);
    chk_b(wr_valid | done | nak | cmd_ready, 1'b0);
    srst <= 1'b0;
    repeat (4) @(posedge clk);
    chk_b(cmd_ready & tw_bus_if_i.scl & tw_bus_if_i.sda, 1'b1);
    $display("test reset done");
    foreach (ROWS[k]) begin
      run_row(ROWS[k]);
      $display("test row %0d done", k);
    end
    // Storage stalls: two words fill the buffer, the third byte must be refused.
    wr_ready <= 1'b0;
    run_row(tw_row_t'{1'b0, 7'h36, 8'h10, 8'h03, 24'hc1c2c3, 3'h0, 1'b1});
    wr_ready <= 1'b1;
    repeat (8) @(posedge clk);
    chk_y(mem[8'h10], 8'hc1);
    chk_y(mem[8'h11], 8'hc2);
    chk_y(mem[8'h12], 8'hed);
    chk_b(wr_valid, 1'b0);
    $display("test buffer full done");
    // Reprogrammed low address bits: only the new address is answered.
    addr_low <= 4'h5;
    run_row(tw_row_t'{1'b0, 7'h36, 8'h00, 8'h00, 24'h000000, 3'h0, 1'b1});
    run_row(tw_row_t'{1'b0, 7'h35, 8'h00, 8'h00, 24'h000000, 3'h0, 1'b0});
    $display("test address change done");
    end_sim;
  end

  initial begin
    repeat (97000) @(posedge clk);
    mismatches++;
    $display("[FAIL] %0t watchdog expired", $time);
    end_sim;
  end
endmodule

`default_nettype wire
